// file: core/ubm_pkg.sv
package ubm_pkg;
    // ==========================================================
    // Register byte offsets on the register bus.
    localparam logic [7:0] OFS_DATA_COMPARE_C = 8'h00;
    localparam logic [7:0] OFS_DATA_MASK_C = 8'h04;
    localparam logic [7:0] OFS_BUS_CYCLE_C = 8'h08;
    localparam logic [7:0] OFS_EXEC_COUNT_C = 8'h0C;
    localparam logic [7:0] OFS_ADDR_D_HIGH = 8'h10;
    localparam logic [7:0] OFS_ADDR_D_LOW = 8'h14;
    localparam logic [7:0] OFS_BREAK_CTRL = 8'h18;
    localparam logic [7:0] OFS_ADDR_D_CTRL = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

    // ==========================================================
    // Field positions.
    localparam int XY_EN_BIT = 9;
    localparam int XY_SEL_BIT = 8;
    localparam logic [15:0] BUS_CYCLE_WMASK = 16'h03FF;
    localparam logic [15:0] EXEC_COUNT_WMASK = 16'h0FFF;
    localparam int EXEC_EN_BIT = 0;
    localparam int STAT_HIT_C_BIT = 0;
    localparam int STAT_BREAK_C_BIT = 1;
    localparam int STAT_HIT_D_BIT = 2;

    // ==========================================================
    // Reset values and count constants.
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [31:0] REG32_RESET = 32'h00000000;
    localparam logic [11:0] EXEC_COUNT_LAST = 12'h001;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Operand size encodings (bits 1:0 of the bus-cycle register).
    localparam logic [1:0] SZ_ANY = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;
endpackage : ubm_pkg

// file: core/ubm_cycle_match.sv
`timescale 1ns/1ps
// ==========================================================
// Qualifies one bus cycle against bits 7:0 of a bus-cycle register.
// Each two-bit field: 00 matches anything, 01 first kind, 10 second.
module ubm_cycle_match (
    input wire logic [7:0] cond,
    input wire logic is_dma,
    input wire logic is_write,
    input wire logic is_data,
    input wire logic [1:0] size,
    output logic ok
);
    // A field of 00 or 11 is a don't-care; 01 and 10 pick a kind.
    function automatic logic fld_ok(input logic [1:0] f, input logic second);
        fld_ok = (f == 2'h0) || (f == 2'h3) || (f == 2'h1 && !second) || (f == 2'h2 && second);
    endfunction : fld_ok

    // All four qualifiers must agree with the running cycle.
    always_comb
    begin
        ok = fld_ok(cond[7:6], is_dma) && fld_ok(cond[5:4], is_data)
            && fld_ok(cond[3:2], is_write)
            && (cond[1:0] == ubm_pkg::SZ_ANY || cond[1:0] == size);
    end
endmodule : ubm_cycle_match

// file: core/ubm_data_match.sv
`timescale 1ns/1ps
// ==========================================================
// Masked data compare for channel C with X/Y and byte lane selection.
module ubm_data_match (
    input wire logic [31:0] cmp,
    input wire logic [31:0] msk,
    input wire logic xy_en,
    input wire logic xy_sel,
    input wire logic [1:0] size,
    input wire logic addr0,
    input wire logic [31:0] bus_data,
    input wire logic [15:0] x_data,
    input wire logic [15:0] y_data,
    output logic ok
);
    logic [31:0] val;
    logic [31:0] care;

    // Picks the bus value and the set of bits that take part.
    always_comb
    begin
        care = ~msk;
        val = bus_data;
        if (xy_en)
        begin
            // X uses the upper half, Y the lower half.
            val = xy_sel ? {16'h0000, y_data} : {x_data, 16'h0000};
            care = care & (xy_sel ? 32'h0000FFFF : 32'hFFFF0000);
        end
        else if (size == ubm_pkg::SZ_BYTE)
        begin
            // Odd bytes compare on bits 7:0, even bytes on 15:8.
            val = {16'h0000, bus_data[7:0], bus_data[7:0]};
            care = care & (addr0 ? 32'h000000FF : 32'h0000FF00);
        end
        ok = ((val ^ cmp) & care) == 32'h00000000;
    end
endmodule : ubm_data_match

// file: core/ubm_top.sv
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Mask one excludes bit, zero keeps it.
// - X/Y mode masks only selected half.
// - Byte breaks use lane by address parity.
// - Bus-cycle bits 15..10 read zero.
// - Bit 9 picks internal or X/Y bus.
// - Bit 8 selects X or Y when enabled.
// - Bus-cycle fields qualify every channel C hit.
// - Bus-cycle register clears on power-on reset.
// - Count down hits; break after one.
// - Count is twelve bits, upper bits zero.
// - Short repeat loops do not decrement.
// - Count register clears on power-on reset.
// - Both halves form 32-bit address normally.
// - X/Y mode compares selected half only.
// - X/Y address bit zero is ignored.
// - Address halves clear on power-on reset.
// - X/Y data compare uses selected half.
module ubm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic manual_reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cyc_valid,
    input wire logic cyc_dma,
    input wire logic cyc_write,
    input wire logic cyc_data,
    input wire logic [1:0] cyc_size,
    input wire logic [31:0] cyc_addr,
    input wire logic [31:0] cyc_wdata,
    input wire logic [15:0] x_addr,
    input wire logic [15:0] y_addr,
    input wire logic [15:0] x_data,
    input wire logic [15:0] y_data,
    input wire logic short_repeat,
    output logic break_req,
    output logic irq
);
    // ==========================================================
    // State.
    typedef struct packed {
        logic [31:0] dcmp_c;
        logic [31:0] dmsk_c;
        logic [15:0] bcyc_c;
        logic [15:0] cnt_c;
        logic [15:0] ad_hi;
        logic [15:0] ad_lo;
        logic [15:0] brk_ctl;
        logic [15:0] bcyc_d;
        logic [2:0] irq_st;
        logic [2:0] irq_msk;
        logic wr_pend;
        logic [7:0] wr_ofs;
        logic [31:0] rdata;
        logic brk;
    } ubm_state_t;

    ubm_state_t st_ff;
    ubm_state_t nxt_st;

    logic c_cyc_ok;
    logic c_data_ok;
    logic d_cyc_ok;
    logic c_hit;
    logic d_hit;
    logic d_addr_ok;
    logic take;
    logic [2:0] w1c;

    // ==========================================================
    // Channel C qualifiers and data compare.
    ubm_cycle_match u_cyc_c (
        .cond(st_ff.bcyc_c[7:0]),
        .is_dma(cyc_dma),
        .is_write(cyc_write),
        .is_data(cyc_data),
        .size(cyc_size),
        .ok(c_cyc_ok)
    );

    ubm_data_match u_data_c (
        .cmp(st_ff.dcmp_c),
        .msk(st_ff.dmsk_c),
        .xy_en(st_ff.bcyc_c[ubm_pkg::XY_EN_BIT]),
        .xy_sel(st_ff.bcyc_c[ubm_pkg::XY_SEL_BIT]),
        .size(cyc_size),
        .addr0(cyc_addr[0]),
        .bus_data(cyc_wdata),
        .x_data(x_data),
        .y_data(y_data),
        .ok(c_data_ok)
    );

    // Channel D qualifiers; its own bus-cycle word is kept locally.
    ubm_cycle_match u_cyc_d (
        .cond(st_ff.bcyc_d[7:0]),
        .is_dma(cyc_dma),
        .is_write(cyc_write),
        .is_data(cyc_data),
        .size(cyc_size),
        .ok(d_cyc_ok)
    );

    // Channel D address compare; X/Y addresses drop bit zero.
    always_comb
    begin
        if (!st_ff.bcyc_d[ubm_pkg::XY_EN_BIT])
            d_addr_ok = cyc_addr == {st_ff.ad_hi, st_ff.ad_lo};
        else if (!st_ff.bcyc_d[ubm_pkg::XY_SEL_BIT])
            d_addr_ok = x_addr[15:1] == st_ff.ad_hi[15:1];
        else
            d_addr_ok = y_addr[15:1] == st_ff.ad_lo[15:1];
    end

    // A hit needs the cycle qualifiers and every compare to agree.
    assign c_hit = cyc_valid && c_cyc_ok && c_data_ok;
    assign d_hit = cyc_valid && d_cyc_ok && d_addr_ok;

    // ==========================================================
    // Bus slave: zero wait states, always OKAY.
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign break_req = st_ff.brk;
    assign irq = |(st_ff.irq_st & st_ff.irq_msk);
    assign w1c = (st_ff.wr_pend && st_ff.wr_ofs == ubm_pkg::OFS_IRQ_STATUS)
        ? hwdata[2:0] : 3'h0;

    // Next state: register writes, reads, counting and sticky flags.
    always_comb
    begin
        logic [2:0] ev;
        logic fire;
        ev = 3'h0;
        fire = 1'b0;
        nxt_st = st_ff;
        nxt_st.brk = 1'b0;
        // Completes a write whose address phase was taken last cycle.
        if (st_ff.wr_pend)
        begin
            unique case (st_ff.wr_ofs)
                ubm_pkg::OFS_DATA_COMPARE_C: nxt_st.dcmp_c = hwdata;
                ubm_pkg::OFS_DATA_MASK_C: nxt_st.dmsk_c = hwdata;
                ubm_pkg::OFS_BUS_CYCLE_C:
                    nxt_st.bcyc_c = hwdata[15:0] & ubm_pkg::BUS_CYCLE_WMASK;
                ubm_pkg::OFS_EXEC_COUNT_C:
                    nxt_st.cnt_c = hwdata[15:0] & ubm_pkg::EXEC_COUNT_WMASK;
                ubm_pkg::OFS_ADDR_D_HIGH: nxt_st.ad_hi = hwdata[15:0];
                ubm_pkg::OFS_ADDR_D_LOW: nxt_st.ad_lo = hwdata[15:0];
                ubm_pkg::OFS_BREAK_CTRL: nxt_st.brk_ctl = hwdata[15:0];
                ubm_pkg::OFS_ADDR_D_CTRL:
                    nxt_st.bcyc_d = hwdata[15:0] & ubm_pkg::BUS_CYCLE_WMASK;
                ubm_pkg::OFS_IRQ_MASK: nxt_st.irq_msk = hwdata[2:0];
                default: ;
            endcase
        end
        // Channel C break, optionally after a number of hits.
        if (c_hit)
        begin
            if (!st_ff.brk_ctl[ubm_pkg::EXEC_EN_BIT])
                fire = 1'b1;
            else if (st_ff.cnt_c[11:0] <= ubm_pkg::EXEC_COUNT_LAST)
                fire = 1'b1;
            else if (!short_repeat)
                nxt_st.cnt_c = {4'h0, st_ff.cnt_c[11:0] - 12'h001};
        end
        ev[ubm_pkg::STAT_HIT_C_BIT] = c_hit;
        ev[ubm_pkg::STAT_BREAK_C_BIT] = fire;
        ev[ubm_pkg::STAT_HIT_D_BIT] = d_hit;
        nxt_st.brk = fire || d_hit;
        // Set wins over a write-one clear in the same cycle.
        nxt_st.irq_st = (st_ff.irq_st & ~w1c) | ev;
        // Address phase capture and read data.
        nxt_st.wr_pend = take && hwrite;
        if (take)
            nxt_st.wr_ofs = haddr[7:0];
        if (take && !hwrite)
        begin
            unique case (haddr[7:0])
                ubm_pkg::OFS_DATA_COMPARE_C: nxt_st.rdata = st_ff.dcmp_c;
                ubm_pkg::OFS_DATA_MASK_C: nxt_st.rdata = st_ff.dmsk_c;
                ubm_pkg::OFS_BUS_CYCLE_C: nxt_st.rdata = {16'h0000, st_ff.bcyc_c};
                ubm_pkg::OFS_EXEC_COUNT_C: nxt_st.rdata = {16'h0000, st_ff.cnt_c};
                ubm_pkg::OFS_ADDR_D_HIGH: nxt_st.rdata = {16'h0000, st_ff.ad_hi};
                ubm_pkg::OFS_ADDR_D_LOW: nxt_st.rdata = {16'h0000, st_ff.ad_lo};
                ubm_pkg::OFS_BREAK_CTRL: nxt_st.rdata = {16'h0000, st_ff.brk_ctl};
                ubm_pkg::OFS_ADDR_D_CTRL: nxt_st.rdata = {16'h0000, st_ff.bcyc_d};
                ubm_pkg::OFS_IRQ_STATUS: nxt_st.rdata = {29'h0, st_ff.irq_st};
                ubm_pkg::OFS_IRQ_MASK: nxt_st.rdata = {29'h0, st_ff.irq_msk};
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // Registers; manual reset leaves the configuration as it is.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
        end
        else if (manual_reset)
        begin
            st_ff <= nxt_st;
            st_ff.wr_pend <= 1'b0;
            st_ff.brk <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Checks.
    a_bus_rsv_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.bcyc_c[15:10] == 6'h00 && st_ff.cnt_c[15:12] == 4'h0)
        else $error("reserved bits set");
    a_cnt_dec_one: assert property (@(posedge hclk) disable iff (!hresetn)
        (c_hit && st_ff.brk_ctl[0] && !short_repeat && st_ff.cnt_c[11:0] > 12'h001
        && !st_ff.wr_pend && !manual_reset)
        |=> st_ff.cnt_c[11:0] == $past(st_ff.cnt_c[11:0]) - 12'h001)
        else $error("count did not drop by one");
    a_cnt_rep_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (c_hit && short_repeat && !st_ff.wr_pend) |=> $stable(st_ff.cnt_c))
        else $error("count moved in repeat loop");
    a_break_last: assert property (@(posedge hclk) disable iff (!hresetn)
        (c_hit && st_ff.brk_ctl[0] && st_ff.cnt_c[11:0] == 12'h001 && !manual_reset)
        |=> break_req && st_ff.irq_st[1])
        else $error("no break at last count");
    a_no_early_brk: assert property (@(posedge hclk) disable iff (!hresetn)
        (c_hit && st_ff.brk_ctl[0] && st_ff.cnt_c[11:0] > 12'h001 && !d_hit)
        |=> !break_req)
        else $error("break before count ran out");
    a_mask_excl: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.dmsk_c == 32'hFFFFFFFF && !st_ff.bcyc_c[9] && cyc_size != 2'h1)
        |-> c_data_ok)
        else $error("masked data still compared");
    a_xy_addr_b0: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.bcyc_d[9] && !st_ff.bcyc_d[8] && x_addr[15:1] == st_ff.ad_hi[15:1])
        |-> d_addr_ok)
        else $error("x address bit zero compared");
    a_hit_needs: assert property (@(posedge hclk) disable iff (!hresetn)
        (c_hit && !st_ff.brk_ctl[0] && !manual_reset) |=> break_req && st_ff.irq_st[0])
        else $error("hit did not raise a break");
    a_stat_w1c: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.wr_pend && st_ff.wr_ofs == ubm_pkg::OFS_IRQ_STATUS && hwdata[0] && !c_hit)
        |=> !st_ff.irq_st[0])
        else $error("status bit not cleared");
    c_brk_count: cover property (@(posedge hclk) disable iff (!hresetn)
        c_hit && st_ff.brk_ctl[0] && st_ff.cnt_c[11:0] == 12'h001);
    c_xy_hit: cover property (@(posedge hclk) disable iff (!hresetn)
        c_hit && st_ff.bcyc_c[9]);
    c_d_hit: cover property (@(posedge hclk) disable iff (!hresetn) d_hit);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
endmodule : ubm_top

// file: test/ubm_bus_src.sv
`timescale 1ns/1ps
// ==========================================================
// Monitored bus source: core and DMA cycles seen by the break logic.
module ubm_bus_src (
    input wire logic hclk,
    output logic cyc_valid,
    output logic cyc_dma,
    output logic cyc_write,
    output logic cyc_data,
    output logic [1:0] cyc_size,
    output logic [31:0] cyc_addr,
    output logic [31:0] cyc_wdata,
    output logic [15:0] x_addr,
    output logic [15:0] y_addr,
    output logic [15:0] x_data,
    output logic [15:0] y_data,
    output logic short_repeat
);
    // All lines idle and defined at time zero.
    initial
    begin
        {cyc_valid, cyc_dma, cyc_write, cyc_data, cyc_size, short_repeat} = 7'h00;
        {cyc_addr, cyc_wdata, x_addr, y_addr, x_data, y_data} = 128'h0;
    end

    // One cycle for one clock; afterwards the address and data lines show the inverse so no stale match hides.
    task automatic go(input logic [2:0] k, input logic [1:0] sz, input logic [31:0] a,
        input logic [31:0] d, input logic [31:0] xy, input logic [31:0] xyd, input logic rep);
        @(posedge hclk);
        cyc_valid <= 1'b1;
        {cyc_dma, cyc_write, cyc_data} <= k;
        cyc_size <= sz;
        cyc_addr <= a;
        cyc_wdata <= d;
        {x_addr, y_addr} <= xy;
        {x_data, y_data} <= xyd;
        short_repeat <= rep;
        @(posedge hclk);
        cyc_valid <= 1'b0;
        cyc_addr <= ~a;
        cyc_wdata <= ~d;
        {x_addr, y_addr} <= ~xy;
        {x_data, y_data} <= ~xyd;
    endtask : go
endmodule : ubm_bus_src

// file: test/user_break_match_channels_test.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the channel C and D break match logic.
module user_break_match_channels_test;
    logic hclk, hresetn, manual_reset, hsel, hwrite, hreadyout, break_req, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, seed, r, cmp, msk, d, wd;
    logic [1:0] htrans, csz;
    logic [2:0] hsize;
    logic cyc_valid, cyc_dma, cyc_write, cyc_data, short_repeat, e;
    logic [1:0] cyc_size;
    logic [31:0] cyc_addr, cyc_wdata;
    logic [15:0] x_addr, y_addr, x_data, y_data, cnd;
    int failures, n_checks;
    logic [15:0] dctl [7] = '{16'h0, 16'h0, 16'h0, 16'h200, 16'h200, 16'h300, 16'h300};
    logic [31:0] dadr [7] = '{32'hA5C33C5A, 32'hA5C33C5B, 32'h25C33C5A, 0, 0, 0, 0};
    logic [31:0] dxy [7] = '{0, 0, 0, 32'hA5C20000, 32'hA5C13C5A, 32'h3C5B, 32'hA5C33C58};
    logic dexp [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    // Clock at 125 MHz.
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    ubm_top dut (.hclk(hclk), .hresetn(hresetn), .manual_reset(manual_reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .cyc_valid(cyc_valid), .cyc_dma(cyc_dma), .cyc_write(cyc_write), .cyc_data(cyc_data),
        .cyc_size(cyc_size), .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .x_addr(x_addr),
        .y_addr(y_addr), .x_data(x_data), .y_data(y_data), .short_repeat(short_repeat),
        .break_req(break_req), .irq(irq));

    ubm_bus_src src (.hclk(hclk), .cyc_valid(cyc_valid), .cyc_dma(cyc_dma),
        .cyc_write(cyc_write), .cyc_data(cyc_data), .cyc_size(cyc_size), .cyc_addr(cyc_addr),
        .cyc_wdata(cyc_wdata), .x_addr(x_addr), .y_addr(y_addr), .x_data(x_data),
        .y_data(y_data), .short_repeat(short_repeat));

    // ==========================================================
    // Helpers: random source, expected hit, comparison, bus transfer.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic qual(input logic [1:0] f, input logic v);
        return (f == 2'h0) || (f == 2'h3) || (f == {v, ~v});
    endfunction : qual

    function automatic logic exp_c(input logic [15:0] c, input logic [31:0] cp,
        input logic [31:0] mk, input logic [2:0] k, input logic [1:0] sz, input logic a0,
        input logic [31:0] wd, input logic [31:0] xyd);
        logic [31:0] diff;
        diff = (wd ^ cp) & ~mk;
        if (c[9])
            diff = (xyd ^ cp) & ~mk & (c[8] ? 32'h0000FFFF : 32'hFFFF0000);
        else if (sz == 2'h1)
            // A byte rides on bits 7:0 of the data bus and is seen in both lanes.
            diff = ({16'h0000, wd[7:0], wd[7:0]} ^ cp) & ~mk
                & (a0 ? 32'h000000FF : 32'h0000FF00);
        return qual(c[7:6], k[2]) && qual(c[5:4], k[0]) && qual(c[3:2], k[1])
            && ((c[1:0] == 2'h0) || (c[1:0] == sz)) && (diff == 32'h0);
    endfunction : exp_c

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Single word transfer; waits for ready in both phases, read data lands in rd.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    // Writes all ones, reads back into rd, then restores zero.
    task automatic ones(input logic [7:0] a);
        ahb(1'b1, a, 32'hFFFFFFFF);
        ahb(1'b0, a, 32'h0);
        ahb(1'b1, a, 32'h0);
    endtask : ones

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if ((failures == 0) && (n_checks > 0))
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // Watchdog against a hung handshake.
    initial
    begin
        #400000;
        failures++;
        print_verdict();
    end

    // ==========================================================
    // Main sequence.
    initial
    begin
        {seed, failures, n_checks} = {32'hAA1F6B0C, 32'h0, 32'h0};
        {hresetn, manual_reset, hsel, hwrite, htrans, haddr, hwdata} = 0;
        hsize = 3'h2;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 13; i++)
        begin
            ahb(1'b0, 8'(i * 4), 32'h0);
            check(rd, 32'h0);
        end
        ones(ubm_pkg::OFS_BUS_CYCLE_C);
        check(rd, 32'h000003FF);
        ones(ubm_pkg::OFS_EXEC_COUNT_C);
        check(rd, 32'h00000FFF);
        ones(ubm_pkg::OFS_ADDR_D_HIGH);
        check(rd, 32'h0000FFFF);
        $display("reset and access test done");
        // Random channel C conditions, size always programmed for data breaks.
        for (int n = 0; n < 60; n++)
        begin
            r = rnd();
            cmp = rnd();
            msk = rnd() & rnd();
            if ((n % 8) == 7)
                msk = 32'hFFFFFFFF;
            cnd = {6'h00, r[9:0]};
            if (cnd[1:0] == 2'h0)
                cnd[1:0] = 2'h3;
            csz = r[11] ? cnd[1:0] : (r[13:12] | 2'h1);
            if (cnd[9])
                csz = 2'h2;
            d = r[14] ? cmp ^ (rnd() & msk) : rnd();
            wd = r[19] ? d : ~d;
            // An even-address byte shows its lane 15:8 value on the low byte lines.
            if ((csz == 2'h1) && !r[18])
                wd[7:0] = wd[15:8];
            ahb(1'b1, ubm_pkg::OFS_DATA_COMPARE_C, cmp);
            ahb(1'b1, ubm_pkg::OFS_DATA_MASK_C, msk);
            ahb(1'b1, ubm_pkg::OFS_BUS_CYCLE_C, {16'h0, cnd});
            src.go(r[17:15], csz, {cmp[31:1], r[18]}, wd, rnd(), d, 1'b0);
            e = exp_c(cnd, cmp, msk, r[17:15], csz, r[18], wd, d);
            ahb(1'b0, ubm_pkg::OFS_IRQ_STATUS, 32'h0);
            check({31'h0, rd[0]}, {31'h0, e});
            ahb(1'b1, ubm_pkg::OFS_IRQ_STATUS, 32'h7);
        end
        $display("random match test done");
        // Execution count with a short repeat loop hit in between.
        ahb(1'b1, ubm_pkg::OFS_DATA_COMPARE_C, 32'h12345678);
        ahb(1'b1, ubm_pkg::OFS_DATA_MASK_C, 32'h0);
        ahb(1'b1, ubm_pkg::OFS_BUS_CYCLE_C, 32'h3);
        ahb(1'b1, ubm_pkg::OFS_BREAK_CTRL, 32'h1);
        ahb(1'b1, ubm_pkg::OFS_EXEC_COUNT_C, 32'h3);
        ahb(1'b1, ubm_pkg::OFS_IRQ_STATUS, 32'h7);
        for (int n = 0; n < 4; n++)
        begin
            src.go(3'h0, 2'h3, 32'h1, 32'h12345678, 32'h0, 32'h0, n == 1);
            #1;
            check({31'h0, break_req}, {31'h0, n == 3});
            ahb(1'b0, ubm_pkg::OFS_EXEC_COUNT_C, 32'h0);
            check(rd, (n < 2) ? 32'h2 : 32'h1);
        end
        ahb(1'b0, ubm_pkg::OFS_IRQ_STATUS, 32'h0);
        check({31'h0, rd[1]}, 32'h1);
        check({31'h0, irq}, 32'h0);
        ahb(1'b1, ubm_pkg::OFS_IRQ_MASK, 32'h2);
        #1;
        check({31'h0, irq}, 32'h1);
        ahb(1'b1, ubm_pkg::OFS_IRQ_STATUS, 32'h7);
        #1;
        check({31'h0, irq}, 32'h0);
        ahb(1'b1, ubm_pkg::OFS_BREAK_CTRL, 32'h0);
        $display("execution count test done");
        // Channel D address compare in full, X and Y modes.
        ahb(1'b1, ubm_pkg::OFS_ADDR_D_HIGH, 32'hA5C3);
        ahb(1'b1, ubm_pkg::OFS_ADDR_D_LOW, 32'h3C5A);
        for (int n = 0; n < 7; n++)
        begin
            ahb(1'b1, ubm_pkg::OFS_ADDR_D_CTRL, {16'h0, dctl[n]});
            ahb(1'b1, ubm_pkg::OFS_IRQ_STATUS, 32'h7);
            src.go(3'h0, 2'h2, dadr[n], 32'h0, dxy[n], 32'h0, 1'b0);
            ahb(1'b0, ubm_pkg::OFS_IRQ_STATUS, 32'h0);
            check({31'h0, rd[2]}, {31'h0, dexp[n]});
        end
        $display("channel D test done");
        print_verdict();
    end
endmodule : user_break_match_channels_test
